//--- design/febs_pkg.sv
// Constants, states and timing for the flash erase and bypass sequencer
// What this block does
// - Unlock, unlock, then 20h enters bypass programming mode.
// - In bypass, each byte takes A0h then the address with its data.
// - In bypass only bypass program and bypass exit are valid; others ignored.
// - Bypass exit is 90h then 00h at any address; back to array read.
// - Bulk erase takes six writes; any wrong write returns to array read.
// - Bulk erase failure after its last erase cycle sets the error bit.
// - Erase first programs affected bytes to 00h, then erases to 0FFh.
// - A running bulk erase ignores every command write.
// - Sector erase takes six writes; further confirms in the window add sectors.
// - Each accepted sector confirm restarts the window timer at full length.
// - Erase window flag reads 0 while the timer counts, 1 once erasing.
// - In the window, any command but suspend or resume aborts to array read.
// - While sectors erase, only reset and suspend are taken.
// - Suspend is B0h with a sector select; in the window it ends the window.
// - Toggle bit stops 0.1 to 15 us after suspend, then array read.
// - Suspended: erasing sector reads invalid, no programming, resume or reset only.
// - Reset while suspended leaves the erasing sectors' contents invalid.
// - Resume is 30h with a sector select active.
// - Program or erase of a protected sector is ignored; protect bits read-only.
// - Boot status register: bit 7 security, bits 3..0 sector locks, 6..4 zero.
// - Reset is one F0h write, optionally after the two unlock writes.
// - Reset ignored in programming and bulk erase; sector erase abort takes 25 us.
// - Completion bit reads 0 during erase, 1 after.
// - Toggle bit inverts on each status read while an operation runs.
package febs_pkg;
  localparam logic [11:0] ADDR_U1 = 12'h555;
  localparam logic [11:0] ADDR_U2 = 12'haaa;
  localparam logic [7:0] CMD_U1 = 8'haa;
  localparam logic [7:0] CMD_U2 = 8'h55;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BEXIT1 = 8'h90;
  localparam logic [7:0] CMD_BEXIT2 = 8'h00;
  localparam logic [7:0] CMD_ERSETUP = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] OFS_MAIN_LOCK = 8'h00;
  localparam logic [7:0] OFS_BOOT_LOCK = 8'h01;
  localparam int BIT_DONE = 7;
  localparam int BIT_TOG = 6;
  localparam int BIT_ERR = 5;
  localparam int BIT_WIN = 3;
  localparam int BIT_SECURITY = 7;
  localparam logic [7:0] INVALID_DATA = 8'hff;
  localparam int NSECT = 12;
  localparam int TMR_W = 14;
  localparam int CLK_NS = 10;
  localparam int WINDOW_NS = 100000;
  localparam int RECOV_NS = 25000;
  localparam int SUSP_NS = 100;
  localparam logic [13:0] WINDOW_CYC = 14'(WINDOW_NS / CLK_NS);
  localparam logic [13:0] RECOV_CYC = 14'(RECOV_NS / CLK_NS);
  localparam logic [13:0] SUSP_CYC = 14'((SUSP_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_U1 = 5'h01, S_U2 = 5'h02, S_ERS1 = 5'h03,
    S_ERS2 = 5'h04, S_ERS3 = 5'h05, S_BYP = 5'h06, S_BEXIT = 5'h07,
    S_BPRG = 5'h08, S_PROG = 5'h09, S_BULK = 5'h0a, S_SWIN = 5'h0b,
    S_SERS = 5'h0c, S_SUSPW = 5'h0d, S_SUSP = 5'h0e, S_ERR = 5'h0f,
    S_RECOV = 5'h10
  } febs_state_e;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0, OP_PROG = 2'h1, OP_PRE00 = 2'h2, OP_ERASE = 2'h3
  } febs_op_e;
endpackage

//--- design/febs_sync.sv
// Three-stage pin synchroniser that passes a value once stages two and three agree
`timescale 1ns/100ps
module febs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_val
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, val_ff, nxt_val;
  always_comb begin
    nxt_val = (s2_ff == s3_ff) ? s3_ff : val_ff;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      val_ff <= '0;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      val_ff <= nxt_val;
    end
  end
  assign o_val = val_ff;
endmodule

//--- design/febs_timer.sv
// Loadable down counter shared by window, suspend and recovery waits
`timescale 1ns/100ps
module febs_timer (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [febs_pkg::TMR_W-1:0] i_val,
  output logic [febs_pkg::TMR_W-1:0] o_count,
  output logic o_expire
);
  logic [febs_pkg::TMR_W-1:0] cnt_ff, nxt_cnt;
  always_comb begin
    if (i_load) begin
      nxt_cnt = i_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign o_count = cnt_ff;
  assign o_expire = (cnt_ff == 14'h0001) && !i_load;
endmodule

//--- design/febs_sequencer.sv
// Flash command sequencer: bypass programming, erase, suspend, protection status
`timescale 1ns/100ps
module febs_sequencer #(
  parameter logic [13:0] P_WINDOW_CYC = febs_pkg::WINDOW_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic [7:0] I_MAIN_SEL,
  input wire logic [3:0] I_BOOT_SEL,
  input wire logic I_CSR_SEL,
  input wire logic [7:0] I_MAIN_PROT,
  input wire logic [3:0] I_BOOT_PROT,
  input wire logic I_SECURITY,
  input wire logic [7:0] I_ARRAY_RDATA,
  input wire logic I_ARRAY_DONE,
  input wire logic I_ARRAY_FAIL,
  output logic [7:0] O_RDATA,
  output logic O_RD_VALID,
  output logic O_RD_INVALID,
  output logic [1:0] O_ARRAY_OP,
  output logic [11:0] O_ARRAY_MASK,
  output logic [15:0] O_PROG_ADDR,
  output logic [7:0] O_PROG_DATA,
  output logic [11:0] O_INVALID_MASK,
  output logic O_BYPASS,
  output logic O_BUSY
);
  febs_pkg::febs_state_e state_ff, nxt_state;
  logic [11:0] mask_ff, nxt_mask, inval_ff, nxt_inval;
  logic [15:0] paddr_ff, nxt_paddr;
  logic [7:0] pdata_ff, nxt_pdata, rdata_ff, nxt_rdata;
  logic byp_ff, nxt_byp, phase_ff, nxt_phase, err_ff, nxt_err;
  logic tog_ff, nxt_tog, rdv_ff, rdinv_ff, nxt_rdinv;
  logic [12:0] prot_raw, prot_sync;
  logic [11:0] sel, prot, sel_free;
  logic [7:0] status;
  logic any_sel, security, tmr_load, tmr_exp, toggling, stat_mode;
  logic [13:0] tmr_val, tmr_cnt;
  logic [11:0] a;
  logic [7:0] d;

  function automatic logic is_cmd(input logic [11:0] ad, input logic [7:0] dd,
                                  input logic [11:0] ea, input logic [7:0] ed);
    is_cmd = (ad == ea) && (dd == ed);
  endfunction

  assign prot_raw = {I_SECURITY, I_BOOT_PROT, I_MAIN_PROT};
  febs_sync #(.W(13)) u_prot_sync (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .i_pin(prot_raw),
    .o_val(prot_sync)
  );
  febs_timer u_timer (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .i_load(tmr_load),
    .i_val(tmr_val),
    .o_count(tmr_cnt),
    .o_expire(tmr_exp)
  );

  assign a = I_ADDR[11:0];
  assign d = I_WDATA;
  assign sel = {I_BOOT_SEL, I_MAIN_SEL};
  assign prot = prot_sync[11:0];
  assign security = prot_sync[12];
  assign any_sel = |sel;
  assign sel_free = sel & ~prot;
  assign toggling = state_ff inside {febs_pkg::S_PROG, febs_pkg::S_BULK,
                                     febs_pkg::S_SWIN, febs_pkg::S_SERS,
                                     febs_pkg::S_SUSPW};
  assign stat_mode = toggling || (state_ff == febs_pkg::S_ERR);

  // Command sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_mask = mask_ff;
    nxt_byp = byp_ff;
    nxt_phase = phase_ff;
    nxt_err = err_ff;
    nxt_inval = inval_ff;
    nxt_paddr = paddr_ff;
    nxt_pdata = pdata_ff;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_ff)
      febs_pkg::S_IDLE: begin
        nxt_byp = 1'b0;
        if (I_WR && is_cmd(a, d, febs_pkg::ADDR_U1, febs_pkg::CMD_U1)) begin
          nxt_state = febs_pkg::S_U1;
        end
      end
      febs_pkg::S_U1: begin
        if (I_WR) begin
          nxt_state = is_cmd(a, d, febs_pkg::ADDR_U2, febs_pkg::CMD_U2) ?
                      febs_pkg::S_U2 : febs_pkg::S_IDLE;
        end
      end
      febs_pkg::S_U2: begin
        if (I_WR) begin
          nxt_state = febs_pkg::S_IDLE;
          if (d == febs_pkg::CMD_BYPASS) begin
            nxt_state = febs_pkg::S_BYP;
          end else if (d == febs_pkg::CMD_PROG) begin
            nxt_state = febs_pkg::S_BPRG;
          end else if (is_cmd(a, d, febs_pkg::ADDR_U1, febs_pkg::CMD_ERSETUP)) begin
            nxt_state = febs_pkg::S_ERS1;
          end
        end
      end
      febs_pkg::S_ERS1: begin
        if (I_WR) begin
          nxt_state = is_cmd(a, d, febs_pkg::ADDR_U1, febs_pkg::CMD_U1) ?
                      febs_pkg::S_ERS2 : febs_pkg::S_IDLE;
        end
      end
      febs_pkg::S_ERS2: begin
        if (I_WR) begin
          nxt_state = is_cmd(a, d, febs_pkg::ADDR_U2, febs_pkg::CMD_U2) ?
                      febs_pkg::S_ERS3 : febs_pkg::S_IDLE;
        end
      end
      febs_pkg::S_ERS3: begin
        if (I_WR) begin
          nxt_state = febs_pkg::S_IDLE;
          nxt_phase = 1'b0;
          if (is_cmd(a, d, febs_pkg::ADDR_U1, febs_pkg::CMD_BULK) && (|(~prot))) begin
            nxt_mask = ~prot;
            nxt_state = febs_pkg::S_BULK;
          end else if (d == febs_pkg::CMD_SECT && (|sel_free)) begin
            nxt_mask = sel_free;
            nxt_state = febs_pkg::S_SWIN;
            tmr_load = 1'b1;
            tmr_val = P_WINDOW_CYC;
          end
        end
      end
      febs_pkg::S_BYP: begin
        nxt_byp = 1'b1;
        if (I_WR && d == febs_pkg::CMD_PROG) begin
          nxt_state = febs_pkg::S_BPRG;
        end else if (I_WR && d == febs_pkg::CMD_BEXIT1) begin
          nxt_state = febs_pkg::S_BEXIT;
        end
      end
      febs_pkg::S_BEXIT: begin
        if (I_WR) begin
          nxt_state = (d == febs_pkg::CMD_BEXIT2) ? febs_pkg::S_IDLE : febs_pkg::S_BYP;
        end
      end
      febs_pkg::S_BPRG: begin
        if (I_WR) begin
          nxt_state = byp_ff ? febs_pkg::S_BYP : febs_pkg::S_IDLE;
          if (|sel_free) begin
            nxt_state = febs_pkg::S_PROG;
            nxt_paddr = I_ADDR;
            nxt_pdata = d;
          end
        end
      end
      febs_pkg::S_PROG: begin
        // Writes, reset included, are ignored while a byte programs
        if (I_ARRAY_DONE && I_ARRAY_FAIL) begin
          nxt_state = febs_pkg::S_ERR;
          nxt_err = 1'b1;
          nxt_mask = '0;
        end else if (I_ARRAY_DONE) begin
          nxt_state = byp_ff ? febs_pkg::S_BYP : febs_pkg::S_IDLE;
        end
      end
      febs_pkg::S_SWIN: begin
        if (tmr_exp) begin
          nxt_state = febs_pkg::S_SERS;
        end
        if (I_WR) begin
          if (d == febs_pkg::CMD_SECT && any_sel) begin
            nxt_state = febs_pkg::S_SWIN;
            nxt_mask = mask_ff | sel_free;
            tmr_load = 1'b1;
            tmr_val = P_WINDOW_CYC;
          end else if (d == febs_pkg::CMD_SUSPEND && any_sel) begin
            nxt_state = febs_pkg::S_SUSPW;
            tmr_load = 1'b1;
            tmr_val = febs_pkg::SUSP_CYC;
          end else begin
            nxt_state = febs_pkg::S_IDLE;
            nxt_mask = '0;
          end
        end
      end
      febs_pkg::S_BULK, febs_pkg::S_SERS, febs_pkg::S_SUSPW: begin
        if (I_ARRAY_DONE && I_ARRAY_FAIL) begin
          nxt_state = febs_pkg::S_ERR;
          nxt_err = 1'b1;
        end else if (I_ARRAY_DONE && !phase_ff) begin
          nxt_phase = 1'b1;
        end else if (I_ARRAY_DONE) begin
          nxt_state = febs_pkg::S_IDLE;
          nxt_mask = '0;
        end else if (state_ff == febs_pkg::S_SUSPW) begin
          if (tmr_exp) begin
            nxt_state = febs_pkg::S_SUSP;
          end
        end else if (state_ff == febs_pkg::S_SERS && I_WR) begin
          if (d == febs_pkg::CMD_RESET) begin
            nxt_state = febs_pkg::S_RECOV;
            nxt_mask = '0;
            tmr_load = 1'b1;
            tmr_val = febs_pkg::RECOV_CYC;
          end else if (d == febs_pkg::CMD_SUSPEND && any_sel) begin
            nxt_state = febs_pkg::S_SUSPW;
            tmr_load = 1'b1;
            tmr_val = febs_pkg::SUSP_CYC;
          end
        end
      end
      febs_pkg::S_SUSP: begin
        if (I_WR && d == febs_pkg::CMD_RESUME && any_sel) begin
          nxt_state = febs_pkg::S_SERS;
        end else if (I_WR && d == febs_pkg::CMD_RESET) begin
          nxt_state = febs_pkg::S_RECOV;
          nxt_inval = inval_ff | mask_ff;
          nxt_mask = '0;
          tmr_load = 1'b1;
          tmr_val = febs_pkg::RECOV_CYC;
        end
      end
      febs_pkg::S_ERR: begin
        if (I_WR && d == febs_pkg::CMD_RESET) begin
          nxt_state = febs_pkg::S_RECOV;
          nxt_err = 1'b0;
          nxt_mask = '0;
          tmr_load = 1'b1;
          tmr_val = febs_pkg::RECOV_CYC;
        end
      end
      febs_pkg::S_RECOV: begin
        if (tmr_exp) begin
          nxt_state = febs_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_state = febs_pkg::S_IDLE;
      end
    endcase
  end

  // Status byte and read path
  always_comb begin
    status = '0;
    status[febs_pkg::BIT_DONE] = (state_ff == febs_pkg::S_PROG ||
                                  (state_ff == febs_pkg::S_ERR && mask_ff == '0)) ?
                                 ~pdata_ff[7] : 1'b0;
    status[febs_pkg::BIT_TOG] = tog_ff;
    status[febs_pkg::BIT_ERR] = err_ff;
    status[febs_pkg::BIT_WIN] = (state_ff != febs_pkg::S_SWIN);
    nxt_tog = tog_ff ^ (I_RD && any_sel && toggling);
    nxt_rdinv = 1'b0;
    nxt_rdata = rdata_ff;
    if (I_RD && I_CSR_SEL) begin
      if (I_ADDR[7:0] == febs_pkg::OFS_MAIN_LOCK) begin
        nxt_rdata = prot_sync[7:0];
      end else if (I_ADDR[7:0] == febs_pkg::OFS_BOOT_LOCK) begin
        nxt_rdata = {security, 3'h0, prot_sync[11:8]};
      end else begin
        nxt_rdata = '0;
      end
    end else if (I_RD && stat_mode && any_sel) begin
      nxt_rdata = status;
    end else if (I_RD && state_ff == febs_pkg::S_SUSP && (|(sel & mask_ff))) begin
      nxt_rdata = febs_pkg::INVALID_DATA;
      nxt_rdinv = 1'b1;
    end else if (I_RD) begin
      nxt_rdata = I_ARRAY_RDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      state_ff <= febs_pkg::S_IDLE;
      mask_ff <= '0;
      inval_ff <= '0;
      paddr_ff <= '0;
      pdata_ff <= '0;
      byp_ff <= 1'b0;
      phase_ff <= 1'b0;
      err_ff <= 1'b0;
      tog_ff <= 1'b0;
      rdata_ff <= '0;
      rdv_ff <= 1'b0;
      rdinv_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mask_ff <= nxt_mask;
      inval_ff <= nxt_inval;
      paddr_ff <= nxt_paddr;
      pdata_ff <= nxt_pdata;
      byp_ff <= nxt_byp;
      phase_ff <= nxt_phase;
      err_ff <= nxt_err;
      tog_ff <= nxt_tog;
      rdata_ff <= nxt_rdata;
      rdv_ff <= I_RD;
      rdinv_ff <= nxt_rdinv;
    end
  end

  always_comb begin
    O_ARRAY_OP = febs_pkg::OP_NONE;
    if (state_ff == febs_pkg::S_PROG) begin
      O_ARRAY_OP = febs_pkg::OP_PROG;
    end else if (state_ff inside {febs_pkg::S_BULK, febs_pkg::S_SERS,
                                  febs_pkg::S_SUSPW}) begin
      O_ARRAY_OP = phase_ff ? febs_pkg::OP_ERASE : febs_pkg::OP_PRE00;
    end
  end
  assign O_RDATA = rdata_ff;
  assign O_RD_VALID = rdv_ff;
  assign O_RD_INVALID = rdinv_ff;
  assign O_ARRAY_MASK = mask_ff;
  assign O_PROG_ADDR = paddr_ff;
  assign O_PROG_DATA = pdata_ff;
  assign O_INVALID_MASK = inval_ff;
  assign O_BYPASS = byp_ff;
  assign O_BUSY = toggling || (state_ff inside {febs_pkg::S_SUSP, febs_pkg::S_RECOV});

  property p_byp_enter;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_U2 && I_WR && d == febs_pkg::CMD_BYPASS) |=>
    (state_ff == febs_pkg::S_BYP) ##1 O_BYPASS;
  endproperty
  a_byp_enter: assert property (p_byp_enter) else $error("bypass entry missed");
  property p_byp_stay;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_BYP && I_WR && d != febs_pkg::CMD_PROG &&
     d != febs_pkg::CMD_BEXIT1) |=> state_ff == febs_pkg::S_BYP;
  endproperty
  a_byp_stay: assert property (p_byp_stay) else $error("bypass left on invalid");
  property p_byp_exit;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_BEXIT && I_WR && d == febs_pkg::CMD_BEXIT2) |=>
    state_ff == febs_pkg::S_IDLE ##1 !O_BYPASS;
  endproperty
  a_byp_exit: assert property (p_byp_exit) else $error("bypass exit failed");
  property p_bulk_deaf;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_BULK && I_WR && !I_ARRAY_DONE) |=>
    state_ff == febs_pkg::S_BULK && $stable(mask_ff);
  endproperty
  a_bulk_deaf: assert property (p_bulk_deaf) else $error("bulk erase took a write");
  property p_win_restart;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_SWIN && I_WR && d == febs_pkg::CMD_SECT && any_sel) |=>
    tmr_cnt == P_WINDOW_CYC ##1 tmr_cnt == P_WINDOW_CYC - 14'h0001;
  endproperty
  a_win_restart: assert property (p_win_restart) else $error("window not restarted");
  property p_win_flag;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (I_RD && any_sel && !I_CSR_SEL && state_ff == febs_pkg::S_SWIN) |=>
    O_RD_VALID && !O_RDATA[febs_pkg::BIT_WIN] && !O_RDATA[febs_pkg::BIT_DONE];
  endproperty
  a_win_flag: assert property (p_win_flag) else $error("window flag wrong");
  property p_win_abort;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_SWIN && I_WR && d != febs_pkg::CMD_SECT &&
     d != febs_pkg::CMD_SUSPEND) |=> state_ff == febs_pkg::S_IDLE && mask_ff == '0;
  endproperty
  a_win_abort: assert property (p_win_abort) else $error("window not aborted");
  property p_susp_refuse;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_SUSP && I_WR && d == febs_pkg::CMD_PROG) |=>
    state_ff == febs_pkg::S_SUSP && O_ARRAY_OP == febs_pkg::OP_NONE;
  endproperty
  a_susp_refuse: assert property (p_susp_refuse) else $error("suspend took program");
  property p_prot_prog;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_BPRG && I_WR && sel_free == '0) |=>
    O_ARRAY_OP == febs_pkg::OP_NONE;
  endproperty
  a_prot_prog: assert property (p_prot_prog) else $error("protected sector programmed");
  property p_recov;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_ff == febs_pkg::S_SERS && I_WR && d == febs_pkg::CMD_RESET && !I_ARRAY_DONE) |=>
    state_ff == febs_pkg::S_RECOV && tmr_cnt == febs_pkg::RECOV_CYC;
  endproperty
  a_recov: assert property (p_recov) else $error("reset abort timing wrong");
endmodule

//--- verification/febs_array_model.sv
// Array engine stand-in: answers each array operation after a set delay
`timescale 1ns/100ps
module febs_array_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [1:0] i_op,
  input wire logic [15:0] i_dly,
  input wire logic i_fail_en,
  output logic o_done,
  output logic o_fail,
  output logic [7:0] o_rdata
);
  logic [15:0] cnt_ff;
  logic [1:0] op_ff;
  logic hit;
  assign hit = (i_op != 2'h0) && (i_op == op_ff) && (cnt_ff == i_dly);
  always_ff @(posedge i_clk) begin
    op_ff <= i_srst ? 2'h0 : i_op;
    cnt_ff <= (i_srst || i_op != op_ff) ? 16'h0 : cnt_ff + 16'h1;
    o_done <= !i_srst && hit;
    o_fail <= !i_srst && hit && i_fail_en && (i_op == 2'h3);
    // Read data churns so a stale value is never mistaken for a fresh one
    o_rdata <= i_srst ? 8'h5a : ~o_rdata ^ cnt_ff[7:0];
  end
endmodule

//--- verification/test_flash_erase_bypass_sequencer.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module test_flash_erase_bypass_sequencer;
  logic clk = 0, srst = 1, wr = 0, rd = 0, csel = 0, sec = 0, fen = 0;
  logic [15:0] addr = 0, dly = 16'h00c8;
  logic [7:0] wd = 0, msel = 0, mprot = 0, pd;
  logic [3:0] bsel = 0, bprot = 0;
  logic [7:0] rdat, ard, opd;
  logic rv, rinv, adone, afail, byp, busy;
  logic [1:0] aop;
  logic [11:0] amask, imask;
  logic [15:0] pa;
  logic [31:0] lf = 32'h3ece8373;
  logic [8:0] exp_q[$];
  logic [8:0] msk_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  febs_sequencer #(.P_WINDOW_CYC(14'h0032)) febs_sequencer_inst (
    .I_CLK_SYS(clk), .I_SRST(srst), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
    .I_WDATA(wd), .I_MAIN_SEL(msel), .I_BOOT_SEL(bsel), .I_CSR_SEL(csel),
    .I_MAIN_PROT(mprot), .I_BOOT_PROT(bprot), .I_SECURITY(sec),
    .I_ARRAY_RDATA(ard), .I_ARRAY_DONE(adone), .I_ARRAY_FAIL(afail),
    .O_RDATA(rdat), .O_RD_VALID(rv), .O_RD_INVALID(rinv), .O_ARRAY_OP(aop),
    .O_ARRAY_MASK(amask), .O_PROG_ADDR(pa), .O_PROG_DATA(opd),
    .O_INVALID_MASK(imask), .O_BYPASS(byp), .O_BUSY(busy));
  febs_array_model febs_array_model_inst (.i_clk(clk), .i_srst(srst), .i_op(aop),
    .i_dly(dly), .i_fail_en(fen), .o_done(adone), .o_fail(afail), .o_rdata(ard));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] expv);
    cmp_count++;
    if (got !== expv) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, expv);
    end
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d, input logic [7:0] s);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = d;
    msel = s;
    @(negedge clk);
    wr = 0;
    msel = 0;
  endtask
  task automatic r(input logic [15:0] a, input logic [7:0] s, input logic c,
                   input logic [8:0] e, input logic [8:0] m);
    @(negedge clk);
    rd = 1;
    addr = a;
    msel = s;
    csel = c;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge clk);
    rd = 0;
    msel = 0;
    csel = 0;
  endtask
  task automatic ul();
    w(16'h0555, 8'haa, 0);
    w(16'h0aaa, 8'h55, 0);
  endtask
  task automatic es(input logic [7:0] s);
    ul();
    w(16'h0555, febs_pkg::CMD_ERSETUP, 0);
    ul();
    w(16'h0000, febs_pkg::CMD_SECT, s);
  endtask
  task automatic wi(input int n);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < n) begin
      @(negedge clk);
      k++;
    end
    chk({15'h0, busy}, 16'h0);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      chk({7'h0, {rinv, rdat} & msk_q[0]}, {7'h0, exp_q[0] & msk_q[0]});
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk);
    srst = 0;
    lf = lfsr(lf);
    mprot = (lf[7:0] | 8'h80) & 8'hfc;
    bprot = lf[11:8];
    sec = lf[12];
    repeat (6) @(negedge clk);
    r(16'h0000, 0, 1, {1'b0, mprot}, 9'h1ff);
    r(16'h0001, 0, 1, {1'b0, sec, 3'h0, bprot}, 9'h1ff);
    w(0, febs_pkg::CMD_RESET, 0);
    ul();
    w(febs_pkg::ADDR_U1, febs_pkg::CMD_BYPASS, 0);
    @(negedge clk);
    chk(byp, 1);
    w(0, febs_pkg::CMD_ERSETUP, 0);
    chk({busy, byp}, 1);
    lf = lfsr(lf);
    pd = lf[7:0];
    w(0, febs_pkg::CMD_PROG, 0);
    w(lf[31:16], pd, 8'h01);
    chk({aop, opd, pa}, {2'h1, pd, lf[31:16]});
    r(lf[31:16], 8'h01, 0, {1'b0, ~pd[7], 7'h0}, 9'h0c0);
    r(lf[31:16], 8'h01, 0, {1'b0, ~pd[7], 7'h40}, 9'h0c0);
    wi(300);
    chk(byp, 1);
    w(0, febs_pkg::CMD_BEXIT1, 0);
    w(0, febs_pkg::CMD_BEXIT2, 0);
    @(negedge clk);
    chk(byp, 0);
    es(8'h80);
    chk(busy, 0);
    ul();
    w(febs_pkg::ADDR_U1, febs_pkg::CMD_PROG, 0);
    w(16'h0000, pd, 8'h80);
    chk({busy, aop}, 0);
    es(8'h01);
    r(0, 8'h01, 0, 9'h000, 9'h088);
    repeat (20) @(negedge clk);
    w(0, febs_pkg::CMD_SECT, 8'h02);
    repeat (44) @(negedge clk);
    r(0, 8'h01, 0, 9'h000, 9'h008);
    repeat (10) @(negedge clk);
    r(0, 8'h01, 0, 9'h008, 9'h088);
    chk(amask, 12'h003);
    w(0, febs_pkg::CMD_PROG, 8'h01);
    chk(aop, 2);
    w(0, febs_pkg::CMD_SUSPEND, 8'h01);
    repeat (12) @(negedge clk);
    chk(aop, 0);
    r(0, 8'h01, 0, 9'h1ff, 9'h1ff);
    r(0, 8'h04, 0, 9'h000, 9'h100);
    w(0, febs_pkg::CMD_PROG, 8'h04);
    chk({busy, aop}, 4);
    w(0, febs_pkg::CMD_RESUME, 8'h01);
    @(negedge clk);
    chk({15'h0, aop != 0}, 1);
    wi(900);
    es(8'h01);
    w(0, febs_pkg::CMD_PROG, 0);
    chk(busy, 0);
    es(8'h01);
    repeat (60) @(negedge clk);
    w(0, febs_pkg::CMD_RESET, 8'h01);
    repeat (2400) @(negedge clk);
    chk(busy, 1);
    wi(200);
    es(8'h01);
    w(0, febs_pkg::CMD_SUSPEND, 8'h01);
    repeat (12) @(negedge clk);
    w(0, febs_pkg::CMD_RESET, 0);
    wi(2600);
    chk(imask, 12'h001);
    fen = 1;
    dly = 16'h0014;
    ul();
    w(16'h0555, febs_pkg::CMD_ERSETUP, 0);
    ul();
    w(16'h0555, febs_pkg::CMD_BULK, 0);
    w(0, febs_pkg::CMD_RESET, 8'h01);
    chk({15'h0, aop != 0}, 1);
    repeat (60) @(negedge clk);
    r(0, 8'h01, 0, 9'h020, 9'h020);
    fen = 0;
    w(0, febs_pkg::CMD_RESET, 0);
    wi(2600);
    close_out();
  end
endmodule
